// >>> regbank_pkg.sv
// How it works
// - read/write bits store writes, read back
// - read-only bits ignore writes
// - write-only bits accept writes, read back zero
// - reserved bits always read zero
// - read-only fields never show reserved encodings
// - resets restore values, software reset spares debug
// - clear register ones clear shared bits
// - set register ones set shared bits
// - both pair registers read identical value
// - simultaneous clear beats set
package regbank_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int                  addr_width      = 3;
	localparam int                  data_width      = 8;
	localparam logic [2:0]          ctrl_addr       = 3'h0;
	localparam logic [2:0]          status_addr     = 3'h1;
	localparam logic [2:0]          cmd_addr        = 3'h2;
	localparam logic [2:0]          flags_set_addr  = 3'h3;
	localparam logic [2:0]          bit_clear_register_addr = 3'h4;
	localparam logic [2:0]          debug_ctrl_addr = 3'h5;

	// ----------------------------------------
	// field layouts and reset values
	// ----------------------------------------
	// ctrl: [3:0] read/write, [5:4] mode field, [7:6] reserved
	localparam logic [7:0]          ctrl_mask       = 8'h3f;
	localparam logic [7:0]          ctrl_reset      = 8'h00;
	localparam logic [7:0]          flags_reset     = 8'h00;
	localparam logic [7:0]          debug_mask      = 8'h01;
	localparam logic [7:0]          debug_reset     = 8'h00;
	// status: [1:0] state field, [7:2] reserved
	localparam logic [7:0]          status_mask     = 8'h03;
	localparam logic [1:0]          mode_reserved   = 2'h3;
	localparam int                  mode_lsb        = 4;
	localparam int                  mode_width      = 2;
	localparam int                  cmd_bit         = 0;
	localparam logic [7:0]          zero_byte       = 8'h00;

	typedef enum logic [1:0] {
		st_idle,
		st_busy,
		st_done
	} state_type;

	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [2:0]             addr;
		logic [7:0]             wdata;
	} bus_req_type;

endpackage : regbank_pkg

// >>> regbank.sv
`timescale 1ns/10ps
module regbank (
	// clock and resets
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   soft_rst,
	// register access
	input  wire regbank_pkg::bus_req_type req,
	output logic [7:0]                  rdata,
	// block outputs
	output logic [7:0]                  ctrl_out,
	output logic [7:0]                  flags_out,
	output logic [7:0]                  debug_out,
	output logic                        cmd_pulse
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]                 ctrl_reg, ctrl_next;
	logic [7:0]                 flags_reg, flags_next;
	logic [7:0]                 debug_reg, debug_next;
	logic [7:0]                 rdata_reg, rdata_next;
	logic                       cmd_reg, cmd_next;
	regbank_pkg::state_type     state_reg, state_next;
	logic [7:0]                 set_bits, clear_bits;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		ctrl_next  = ctrl_reg;
		flags_next = flags_reg;
		debug_next = debug_reg;
		cmd_next   = 1'b0;
		state_next = state_reg;
		set_bits   = regbank_pkg::zero_byte;
		clear_bits = regbank_pkg::zero_byte;
		if (req.wr) begin
			case (req.addr)
				regbank_pkg::ctrl_addr: begin
					ctrl_next = req.wdata & regbank_pkg::ctrl_mask;
					// a reserved mode code is refused; keep old field
					if (req.wdata[regbank_pkg::mode_lsb +: regbank_pkg::mode_width]
							== regbank_pkg::mode_reserved) begin
						ctrl_next[regbank_pkg::mode_lsb +: regbank_pkg::mode_width] =
							ctrl_reg[regbank_pkg::mode_lsb +: regbank_pkg::mode_width];
					end
				end
				// write-only command strobe, not stored
				regbank_pkg::cmd_addr: cmd_next = req.wdata[regbank_pkg::cmd_bit];
				regbank_pkg::flags_set_addr: set_bits = req.wdata;
				regbank_pkg::bit_clear_register_addr: clear_bits = req.wdata;
				default: ;
			endcase
			if (req.addr == regbank_pkg::debug_ctrl_addr) begin
				debug_next = req.wdata & regbank_pkg::debug_mask;
			end
			// status writes fall in default: ignored
		end
		// zeros change nothing; clear applied last so it wins
		flags_next = (flags_reg | set_bits)
			& ~clear_bits;
		case (state_reg)
			regbank_pkg::st_idle: if (cmd_next) state_next = regbank_pkg::st_busy;
			regbank_pkg::st_busy: state_next = regbank_pkg::st_done;
			regbank_pkg::st_done: state_next = regbank_pkg::st_idle;
			default: state_next = regbank_pkg::st_idle;
		endcase
		// software reset spares the debug control register
		if (soft_rst) begin
			ctrl_next  = regbank_pkg::ctrl_reset;
			flags_next = regbank_pkg::flags_reset;
			cmd_next   = 1'b0;
			state_next = regbank_pkg::st_idle;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rdata_next = regbank_pkg::zero_byte;
		if (req.rd) begin
			case (req.addr)
				regbank_pkg::ctrl_addr: rdata_next = ctrl_reg;
				regbank_pkg::status_addr:
					rdata_next = 8'(state_reg) & regbank_pkg::status_mask;
				// pair registers both show the one shared state
				regbank_pkg::flags_set_addr: rdata_next = flags_reg;
				regbank_pkg::bit_clear_register_addr: rdata_next = flags_reg;
				regbank_pkg::debug_ctrl_addr: rdata_next = debug_reg;
				default: rdata_next = regbank_pkg::zero_byte;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg  <= regbank_pkg::ctrl_reset;
			flags_reg <= regbank_pkg::flags_reset;
			debug_reg <= regbank_pkg::debug_reset;
			rdata_reg <= regbank_pkg::zero_byte;
			cmd_reg   <= 1'b0;
			state_reg <= regbank_pkg::st_idle;
		end else begin
			ctrl_reg  <= ctrl_next;
			flags_reg <= flags_next;
			debug_reg <= debug_next;
			rdata_reg <= rdata_next;
			cmd_reg   <= cmd_next;
			state_reg <= state_next;
		end
	end

	assign rdata     = rdata_reg;
	assign ctrl_out  = ctrl_reg;
	assign flags_out = flags_reg;
	assign debug_out = debug_reg;
	assign cmd_pulse = cmd_reg;

endmodule : regbank

// >>> regbank_asserts.sv
`timescale 1ns/10ps
module regbank_asserts (
	// watched ports
	input wire logic                     clk,
	input wire logic                     nrst,
	input wire logic                     soft_rst,
	input wire regbank_pkg::bus_req_type req,
	input wire logic [7:0]               rdata,
	input wire logic [7:0]               ctrl_out,
	input wire logic [7:0]               flags_out,
	input wire logic [7:0]               debug_out,
	input wire logic                     cmd_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire w = req.wr && !soft_rst;
	wire r = req.rd;
	wire [2:0] a = req.addr;
	a_rd_zero: assert property ((!r || a == 3'h2) |=> rdata == 8'h00)
		else $error("rdata not zero");
	a_ctrl_rsvd: assert property (ctrl_out[7:6] == 2'h0)
		else $error("ctrl reserved set");
	a_ctrl_rd: assert property (r && a == 3'h0 |=> rdata == $past(ctrl_out))
		else $error("ctrl readback");
	a_pair_same: assert property (r && (a == 3'h3 || a == 3'h4)
		|=> rdata == $past(flags_out)) else $error("pair readback");
	a_pair_clear: assert property (w && a == 3'h4
		|=> flags_out == ($past(flags_out) & ~$past(req.wdata)))
		else $error("clear wrong");
	a_pair_set: assert property (w && a == 3'h3
		|=> flags_out == ($past(flags_out) | $past(req.wdata)))
		else $error("set wrong");
	a_status_ok: assert property (r && a == 3'h1
		|=> rdata[1:0] != 2'h3 && rdata[7:2] == 6'h00) else $error("status bad");
	a_soft_rst: assert property (soft_rst && !req.wr |=> ctrl_out == 8'h00
		&& flags_out == 8'h00 && $stable(debug_out)) else $error("soft reset");
	a_cmd_pulse: assert property (w && a == 3'h2 && req.wdata[0]
		|=> cmd_pulse) else $error("no cmd pulse");
endmodule : regbank_asserts
bind regbank regbank_asserts chk (.clk(clk), .nrst(nrst), .soft_rst(soft_rst),
	.req(req), .rdata(rdata), .ctrl_out(ctrl_out), .flags_out(flags_out),
	.debug_out(debug_out), .cmd_pulse(cmd_pulse));

// >>> cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
	input  wire logic                clk,
	output regbank_pkg::bus_req_type req
);
	initial req = '0;
	// one request per call; idle gap avoids double drive in one step
	task op(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{w, !w, a, d};
		@(posedge clk);
		#1 req = '{1'b0, 1'b0, ~a, ~d};
	endtask : op
endmodule : cpu_model

// >>> regbank_test.sv
`timescale 1ns/10ps
module regbank_test;
	logic clk = 0, nrst = 0, soft_rst = 0, cmd_pulse;
	logic [7:0] rdata, ctrl_out, flags_out, debug_out, v;
	regbank_pkg::bus_req_type req;
	int num_errors = 0, total_checks = 0;
	cpu_model cpu (.clk(clk), .req(req));
	regbank dut (.clk(clk), .nrst(nrst), .soft_rst(soft_rst), .req(req),
		.rdata(rdata), .ctrl_out(ctrl_out), .flags_out(flags_out),
		.debug_out(debug_out), .cmd_pulse(cmd_pulse));
	initial forever #50 clk = ~clk;
	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task rc(input logic [2:0] a, input logic [7:0] e);
		cpu.op(1'b0, a, 8'h00);
		chk(rdata, e);
	endtask : rc
	task end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task t_rw;
		cpu.op(1'b1, 3'h0, 8'h1f);
		rc(3'h0, 8'h1f);
		cpu.op(1'b1, 3'h0, 8'h25);
		rc(3'h0, 8'h25);
		rc(3'h6, 8'h00);
	endtask : t_rw
	task t_ro;
		cpu.op(1'b0, 3'h1, 8'h00);
		v = rdata;
		cpu.op(1'b1, 3'h1, 8'hff);
		rc(3'h1, v);
		chk(v & 8'hfc, 8'h00);
	endtask : t_ro
	task t_cmd;
		cpu.op(1'b1, 3'h2, 8'h01);
		chk({7'h00, cmd_pulse}, 8'h01);
		rc(3'h2, 8'h00);
	endtask : t_cmd
	task t_pair;
		cpu.op(1'b1, 3'h3, 8'h05);
		cpu.op(1'b1, 3'h4, 8'h01);
		rc(3'h3, 8'h04);
		rc(3'h4, 8'h04);
		cpu.op(1'b1, 3'h3, 8'h00);
		cpu.op(1'b1, 3'h4, 8'h00);
		chk(flags_out, 8'h04);
	endtask : t_pair
	task t_rst;
		cpu.op(1'b1, 3'h5, 8'h01);
		cpu.op(1'b1, 3'h3, 8'h80);
		soft_rst = 1;
		@(posedge clk);
		#1 soft_rst = 0;
		chk(flags_out | ctrl_out, 8'h00);
		chk(debug_out, 8'h01);
		nrst = 0;
		#10 chk(debug_out, 8'h00);
		@(posedge clk);
		#1 nrst = 1;
	endtask : t_rst
	initial begin
		repeat (6) @(posedge clk);
		#1 nrst = 1;
		t_rw;
		t_ro;
		t_cmd;
		t_pair;
		t_rst;
		end_sim;
	end
	initial begin
		#100000;
		num_errors++;
		end_sim;
	end
endmodule : regbank_test
